// ===== rtl/clock_select_control.v
/*
 * System clock select and oscillator control with an Avalon-MM register slave.
 * Assumes oscillator outputs and ready levels arrive from outside the clk_sys
 * domain, oscillators run below half of clk_sys, and halt and wake are
 * one-cycle pulses from logic on clk_sys.
 */
// Chosen here: register access over Avalon-MM and the address map.
// Summary of operation
// - Select code picks high clock divisor or sub
// - High source bit picks fast RC or crystal
// - Low source is slow RC; one is reserved
// - High keep bit runs high oscillator in halt
// - Low keep bit runs low oscillator in halt
// - Bit four of clock control reads zero
// - Switch completes after four current ticks plus handover
// - Frequency code selects 8, 12 or 16 MHz
// - New fast RC frequency delivered after stable flag
// - Fast RC stable flag clears, then sets when stable
// - Fast RC enable starts oscillator; resets to one
// - Crystal range bit selects below or above 10MHz
// - Crystal enable starts it; stable flag clears then sets
// - Select field alone switches fast/slow, never halts
// - Halt chooses sleep or idle by keep bits
// - Keep bits map to sleep and three idle modes
`timescale 1ns/1ps
`include "clock_select_regs.vh"
module clock_select_control #(
    parameter SETTLE_CYCLES = `OSC_SETTLE_CYCLES,
    parameter SWITCH_TICKS = `SWITCH_SYS_TICKS
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    input wire ce,
    // Avalon-MM slave
    input wire [2:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Oscillator outputs and ready levels
    input wire fast_rc_clk,
    input wire crystal_clk,
    input wire slow_rc_clk,
    input wire fast_rc_ready,
    input wire crystal_ready,
    // Oscillator controls
    output wire fast_rc_run,
    output wire [1:0] fast_rc_freq_code,
    output wire crystal_run,
    output wire crystal_range,
    output wire slow_rc_run,
    // CPU side
    input wire halt_req,
    input wire wake_req,
    output wire cpu_clk_en,
    output wire sys_clk_en,
    output reg [2:0] power_mode,
    output reg halted,
    // Interrupt
    output wire irq
);
    localparam [31:0] SETTLE_FULL = SETTLE_CYCLES - 1;
    localparam [15:0] SETTLE_LAST = SETTLE_FULL[15:0];

    // Register fields
    reg [2:0] sysclk_select_reg;
    reg high_src_select_reg;
    reg low_src_select_reg;
    reg high_osc_halt_keep_reg;
    reg low_osc_halt_keep_reg;
    reg [1:0] fast_rc_freq_sel_reg;
    reg fast_rc_enable_reg;
    reg crystal_range_sel_reg;
    reg crystal_enable_reg;
    reg [`EV_WIDTH-1:0] int_status_reg;
    reg [`EV_WIDTH-1:0] int_mask_reg;
    reg [1:0] fast_rc_freq_out_reg;

    // Bus and synchroniser state
    reg ack_reg;
    reg [31:0] rdata;
    reg [4:0] sync1_reg;
    reg [4:0] sync2_reg;
    reg [2:0] tick_prev_reg;
    reg [1:0] stable_prev_reg;

    wire [2:0] tick;
    wire [1:0] osc_run;
    wire [1:0] osc_ready;
    wire [1:0] osc_restart;
    wire [1:0] osc_stable;
    wire [`EV_WIDTH-1:0] event_set;
    wire [`EV_WIDTH-1:0] event_clr;
    wire wr_take;
    wire wr_scc;
    wire wr_frc;
    wire wr_xtl;
    wire wr_stat;
    wire wr_mask;
    wire [7:0] wd;
    wire sw_tick;
    wire [3:0] active_sel;
    wire sw_busy;
    wire sw_done;
    wire active_is_sub;
    wire src_alive;

    // Halt mode from the two keep bits
    function [2:0] halt_mode;
        input keep_high;
        input keep_low;
        begin
            case ({keep_high, keep_low})
                2'b00: halt_mode = `MODE_SLEEP;
                2'b01: halt_mode = `MODE_IDLE_LOW_ONLY;
                2'b11: halt_mode = `MODE_IDLE_BOTH_OSC;
                2'b10: halt_mode = `MODE_IDLE_HIGH_ONLY;
                default: halt_mode = `MODE_SLEEP;
            endcase
        end
    endfunction

    // Bus handshake: one wait state on every access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_take = avs_write & ack_reg & avs_byteenable[0];
    assign wd = avs_writedata[7:0];
    assign wr_scc = wr_take & (avs_address == `IDX_SYSTEM_CLOCK_CONTROL);
    assign wr_frc = wr_take & (avs_address == `IDX_FAST_RC_CONTROL);
    assign wr_xtl = wr_take & (avs_address == `IDX_CRYSTAL_CONTROL);
    assign wr_stat = wr_take & (avs_address == `IDX_INT_STATUS);
    assign wr_mask = wr_take & (avs_address == `IDX_INT_MASK);

    // Pin synchronisers; edges are taken from the second stage only
    assign tick = sync2_reg[2:0] & ~tick_prev_reg;
    assign osc_ready = sync2_reg[4:3];

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            tick_prev_reg <= 3'h0;
        end else if (ce) begin
            sync1_reg <= {crystal_ready, fast_rc_ready, slow_rc_clk, crystal_clk,
                fast_rc_clk};
            sync2_reg <= sync1_reg;
            tick_prev_reg <= sync2_reg[2:0];
        end
    end

    // Oscillator run controls
    assign fast_rc_run = fast_rc_enable_reg & (~halted | high_osc_halt_keep_reg);
    assign crystal_run = crystal_enable_reg & (~halted | high_osc_halt_keep_reg);
    assign slow_rc_run = ~halted | low_osc_halt_keep_reg;
    assign osc_run = {crystal_run, fast_rc_run};
    assign fast_rc_freq_code = fast_rc_freq_sel_reg;
    assign crystal_range = crystal_range_sel_reg;

    // Restart on enable rising or on a new frequency code
    assign osc_restart[0] = wr_frc & ((wd[`FRC_ENABLE] & ~fast_rc_enable_reg) |
        (wd[`FRC_FREQ_HI:`FRC_FREQ_LO] != fast_rc_freq_sel_reg));
    assign osc_restart[1] = wr_xtl & wd[`XTL_ENABLE] & ~crystal_enable_reg;

    // Stable flags: ready must hold for a settle time after each restart
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : stab
            reg [15:0] cnt_reg;
            reg flag_reg;
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    cnt_reg <= 16'h0000;
                    flag_reg <= 1'b0;
                end else if (ce) begin
                    if (~osc_run[i] | osc_restart[i]) begin
                        cnt_reg <= 16'h0000;
                        flag_reg <= 1'b0;
                    end else if (~osc_ready[i]) begin
                        cnt_reg <= 16'h0000;
                    end else if (~flag_reg) begin
                        if (cnt_reg == SETTLE_LAST)
                            flag_reg <= 1'b1;
                        else
                            cnt_reg <= cnt_reg + 16'h0001;
                    end
                end
            end
            assign osc_stable[i] = flag_reg;
        end
    endgenerate

    // Delivered fast RC frequency follows the stable flag
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fast_rc_freq_out_reg <= `FAST_RC_FREQ_RESET;
            stable_prev_reg <= 2'b00;
        end else if (ce) begin
            stable_prev_reg <= osc_stable;
            if (osc_stable[0] & ~stable_prev_reg[0])
                fast_rc_freq_out_reg <= fast_rc_freq_sel_reg;
        end
    end

    // Clock source switch; unstable oscillators deliver no ticks
    clock_switch #(
        .SWITCH_TICKS(SWITCH_TICKS)
    ) u_switch (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .target_sel({high_src_select_reg, sysclk_select_reg}),
        .fast_tick(tick[0] & osc_stable[0]),
        .crystal_tick(tick[1] & osc_stable[1]),
        .slow_tick(tick[2]),
        .sys_tick(sw_tick),
        .active_sel(active_sel),
        .busy(sw_busy),
        .done(sw_done)
    );

    assign active_is_sub = (active_sel[2:0] == `SEL_SUB_CLOCK);
    // In halt the system clock lives only if its own oscillator is kept
    assign src_alive = ~halted |
        (active_is_sub ? low_osc_halt_keep_reg : high_osc_halt_keep_reg);
    assign sys_clk_en = sw_tick & src_alive;
    assign cpu_clk_en = sw_tick & ~halted;

    // Halt and wake; the select field never halts the CPU
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            halted <= 1'b0;
            power_mode <= `MODE_FAST;
        end else if (ce) begin
            if (halted & wake_req) begin
                halted <= 1'b0;
            end else if (~halted & halt_req & ~wake_req) begin
                halted <= 1'b1;
                power_mode <= halt_mode(high_osc_halt_keep_reg,
                    low_osc_halt_keep_reg);
            end
            if (~halted | wake_req)
                power_mode <= active_is_sub ? `MODE_SLOW : `MODE_FAST;
            if (~halted & halt_req & ~wake_req)
                power_mode <= halt_mode(high_osc_halt_keep_reg,
                    low_osc_halt_keep_reg);
        end
    end

    // Interrupt events; a set in the clearing cycle wins
    assign event_set[`EV_FAST_RC_STABLE] = osc_stable[0] & ~stable_prev_reg[0];
    assign event_set[`EV_CRYSTAL_STABLE] = osc_stable[1] & ~stable_prev_reg[1];
    assign event_set[`EV_SWITCH_DONE] = sw_done;
    assign event_clr = wr_stat ? wd[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};
    assign irq = |(int_status_reg & int_mask_reg);

    // Register writes
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sysclk_select_reg <= `SYSCLK_SELECT_RESET;
            high_src_select_reg <= 1'b0;
            low_src_select_reg <= 1'b0;
            high_osc_halt_keep_reg <= 1'b0;
            low_osc_halt_keep_reg <= 1'b0;
            fast_rc_freq_sel_reg <= `FAST_RC_FREQ_RESET;
            fast_rc_enable_reg <= `FAST_RC_ENABLE_RESET;
            crystal_range_sel_reg <= 1'b0;
            crystal_enable_reg <= `CRYSTAL_ENABLE_RESET;
            int_status_reg <= {`EV_WIDTH{1'b0}};
            int_mask_reg <= {`EV_WIDTH{1'b0}};
        end else if (ce) begin
            int_status_reg <= (int_status_reg & ~event_clr) | event_set;
            if (wr_scc) begin
                sysclk_select_reg <= wd[`SCC_SEL_HI:`SCC_SEL_LO];
                high_src_select_reg <= wd[`SCC_HIGH_SRC];
                // Stored for read-back; the sub clock is the slow RC either way
                low_src_select_reg <= wd[`SCC_LOW_SRC];
                high_osc_halt_keep_reg <= wd[`SCC_HIGH_KEEP];
                low_osc_halt_keep_reg <= wd[`SCC_LOW_KEEP];
            end
            if (wr_frc) begin
                fast_rc_freq_sel_reg <= wd[`FRC_FREQ_HI:`FRC_FREQ_LO];
                fast_rc_enable_reg <= wd[`FRC_ENABLE];
            end
            if (wr_xtl) begin
                // A range change under a running crystal is dropped
                if (~crystal_enable_reg)
                    crystal_range_sel_reg <= wd[`XTL_RANGE];
                crystal_enable_reg <= wd[`XTL_ENABLE];
            end
            if (wr_mask)
                int_mask_reg <= wd[`EV_WIDTH-1:0];
        end
    end

    // Read mux; unmapped words and unimplemented bits read zero
    always @* begin
        rdata = 32'h00000000;
        case (avs_address)
            `IDX_SYSTEM_CLOCK_CONTROL: begin
                rdata[`SCC_SEL_HI:`SCC_SEL_LO] = sysclk_select_reg;
                rdata[4] = 1'b0;
                rdata[`SCC_HIGH_SRC] = high_src_select_reg;
                rdata[`SCC_LOW_SRC] = low_src_select_reg;
                rdata[`SCC_HIGH_KEEP] = high_osc_halt_keep_reg;
                rdata[`SCC_LOW_KEEP] = low_osc_halt_keep_reg;
            end
            `IDX_FAST_RC_CONTROL: begin
                rdata[`FRC_FREQ_HI:`FRC_FREQ_LO] = fast_rc_freq_sel_reg;
                rdata[`FRC_STABLE] = osc_stable[0];
                rdata[`FRC_ENABLE] = fast_rc_enable_reg;
            end
            `IDX_CRYSTAL_CONTROL: begin
                rdata[`XTL_RANGE] = crystal_range_sel_reg;
                rdata[`XTL_STABLE] = osc_stable[1];
                rdata[`XTL_ENABLE] = crystal_enable_reg;
            end
            `IDX_INT_STATUS: begin
                rdata[`EV_WIDTH-1:0] = int_status_reg;
            end
            `IDX_INT_MASK: begin
                rdata[`EV_WIDTH-1:0] = int_mask_reg;
            end
            `IDX_SWITCH_STATE: begin
                rdata[3:0] = active_sel;
                rdata[4] = sw_busy;
                rdata[7:5] = power_mode;
                rdata[8] = halted;
                rdata[10:9] = fast_rc_freq_out_reg;
            end
            default: begin
                rdata = 32'h00000000;
            end
        endcase
    end

    // Read data registered in the wait cycle, valid at the accepting edge
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else if (ce) begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
            if (avs_read & ~ack_reg)
                avs_readdata <= rdata;
        end
    end
endmodule // clock_select_control

// ===== inc/clock_select_regs.vh
/*
 * Register indexes, field positions, reset values, mode codes and counts
 * of the system clock select and oscillator control block.
 * Assumes an Avalon-MM word address; byte address is four times the index.
 */
`ifndef CLOCK_SELECT_REGS_VH
`define CLOCK_SELECT_REGS_VH

// Word indexes
`define IDX_SYSTEM_CLOCK_CONTROL 3'h0
`define IDX_FAST_RC_CONTROL 3'h1
`define IDX_CRYSTAL_CONTROL 3'h2
`define IDX_INT_STATUS 3'h3
`define IDX_INT_MASK 3'h4
`define IDX_SWITCH_STATE 3'h5

// System clock control fields
`define SCC_SEL_HI 7
`define SCC_SEL_LO 5
`define SCC_HIGH_SRC 3
`define SCC_LOW_SRC 2
`define SCC_HIGH_KEEP 1
`define SCC_LOW_KEEP 0

// Fast RC control fields
`define FRC_FREQ_HI 3
`define FRC_FREQ_LO 2
`define FRC_STABLE 1
`define FRC_ENABLE 0

// Crystal control fields
`define XTL_RANGE 2
`define XTL_STABLE 1
`define XTL_ENABLE 0

// Reset values
`define SYSCLK_SELECT_RESET 3'h0
`define FAST_RC_FREQ_RESET 2'h0
`define FAST_RC_ENABLE_RESET 1'b1
`define CRYSTAL_ENABLE_RESET 1'b0

// Clock select codes
`define SEL_SUB_CLOCK 3'h7

// Interrupt event bits
`define EV_FAST_RC_STABLE 0
`define EV_CRYSTAL_STABLE 1
`define EV_SWITCH_DONE 2
`define EV_WIDTH 3

// Power mode codes
`define MODE_FAST 3'h0
`define MODE_SLOW 3'h1
`define MODE_SLEEP 3'h2
`define MODE_IDLE_LOW_ONLY 3'h3
`define MODE_IDLE_BOTH_OSC 3'h4
`define MODE_IDLE_HIGH_ONLY 3'h5

// Counts
`define SWITCH_SYS_TICKS 4
`define OSC_SETTLE_CYCLES 16

`endif

// ===== rtl/clock_switch.v
/*
 * Glitch-free system clock source switch, working on clock-enable ticks.
 * Assumes oscillator ticks are one-cycle pulses already in the clk_sys domain.
 */
`timescale 1ns/1ps
`include "clock_select_regs.vh"
module clock_switch #(
    parameter SWITCH_TICKS = `SWITCH_SYS_TICKS
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    input wire ce,
    // Selection {high source, divider code}
    input wire [3:0] target_sel,
    // Oscillator ticks
    input wire fast_tick,
    input wire crystal_tick,
    input wire slow_tick,
    // Result
    output reg sys_tick,
    output reg [3:0] active_sel,
    output wire busy,
    output reg done
);
    localparam ST_IDLE = 2'b00;
    localparam ST_COUNT = 2'b01;
    localparam ST_HANDOVER = 2'b10;
    localparam [31:0] TICK_FULL = SWITCH_TICKS - 1;
    localparam [2:0] TICK_LAST = TICK_FULL[2:0];

    reg [1:0] state_reg;
    reg [2:0] count_reg;
    reg [3:0] pend_reg;
    reg [5:0] fast_div_reg;
    reg [5:0] xtal_div_reg;
    wire cur_tick;
    wire tar_tick;

    // Divide by two to the code: tick when the low bits are all ones
    function sel_tick;
        input [3:0] s;
        input f;
        input x;
        input sl;
        input [5:0] fd;
        input [5:0] xd;
        reg [5:0] mask;
        reg [5:0] cnt;
        begin
            mask = ~(6'h3f << s[2:0]);
            cnt = s[3] ? xd : fd;
            if (s[2:0] == `SEL_SUB_CLOCK)
                sel_tick = sl;
            else
                sel_tick = (s[3] ? x : f) & ((cnt & mask) == mask);
        end
    endfunction

    assign cur_tick = sel_tick(active_sel, fast_tick, crystal_tick, slow_tick,
        fast_div_reg, xtal_div_reg);
    assign tar_tick = sel_tick(pend_reg, fast_tick, crystal_tick, slow_tick,
        fast_div_reg, xtal_div_reg);
    assign busy = (state_reg != ST_IDLE);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            count_reg <= 3'h0;
            pend_reg <= 4'h0;
            active_sel <= 4'h0;
            fast_div_reg <= 6'h00;
            xtal_div_reg <= 6'h00;
            sys_tick <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (fast_tick)
                fast_div_reg <= fast_div_reg + 6'h01;
            if (crystal_tick)
                xtal_div_reg <= xtal_div_reg + 6'h01;
            // Handover gap drops the tick so no shortened cycle reaches the CPU
            sys_tick <= cur_tick & (state_reg != ST_HANDOVER);
            case (state_reg)
                ST_IDLE: begin
                    if (target_sel != active_sel) begin
                        pend_reg <= target_sel;
                        count_reg <= 3'h0;
                        state_reg <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (target_sel != pend_reg) begin
                        state_reg <= ST_IDLE;
                    end else if (cur_tick) begin
                        count_reg <= count_reg + 3'h1;
                        if (count_reg == TICK_LAST)
                            state_reg <= ST_HANDOVER;
                    end
                end
                ST_HANDOVER: begin
                    // A target that never ticks leaves the clock stopped here
                    if (tar_tick) begin
                        active_sel <= pend_reg;
                        done <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // clock_switch

// ===== dv/clock_select_control_properties.sv
/*
 * Concurrent checks on the ports of the clock select control block.
 * Assumes one clk_sys domain, rst async active high, bound to the top module.
 */
`timescale 1ns/1ps
`include "clock_select_regs.vh"
module clock_select_control_properties #(
    parameter SETTLE_CYCLES = `OSC_SETTLE_CYCLES,
    parameter SWITCH_TICKS = `SWITCH_SYS_TICKS
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    input wire ce,
    // Avalon-MM slave
    input wire [2:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Oscillators
    input wire fast_rc_clk,
    input wire crystal_clk,
    input wire slow_rc_clk,
    input wire fast_rc_ready,
    input wire crystal_ready,
    input wire fast_rc_run,
    input wire [1:0] fast_rc_freq_code,
    input wire crystal_run,
    input wire crystal_range,
    input wire slow_rc_run,
    // CPU side
    input wire halt_req,
    input wire wake_req,
    input wire cpu_clk_en,
    input wire sys_clk_en,
    input wire [2:0] power_mode,
    input wire halted,
    input wire irq
);
default clocking cb @(posedge clk_sys); endclocking
default disable iff (rst);

req_wait_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
    |-> avs_waitrequest) else $error("new request answered without a wait state");
one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest && ce
    |=> !avs_waitrequest) else $error("more than one wait state");
bit4_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 3'h0
    |-> !avs_readdata[4] && avs_readdata[31:8] == 24'h0) else $error("bit four read nonzero");
halt_entry_a: assert property (ce && halt_req && !wake_req && !halted
    |=> halted && power_mode >= `MODE_SLEEP && power_mode <= `MODE_IDLE_HIGH_ONLY)
    else $error("halt did not enter sleep or idle");
wake_exit_a: assert property (ce && wake_req |=> !halted) else $error("wake ignored");
awake_mode_a: assert property (!halted |-> power_mode <= `MODE_SLOW && slow_rc_run)
    else $error("running mode wrong while awake");
keep_low_a: assert property (halted |-> slow_rc_run == (power_mode == `MODE_IDLE_LOW_ONLY
    || power_mode == `MODE_IDLE_BOTH_OSC)) else $error("low oscillator run wrong in halt");
keep_high_a: assert property (halted && (power_mode == `MODE_SLEEP
    || power_mode == `MODE_IDLE_LOW_ONLY) |-> !fast_rc_run && !crystal_run)
    else $error("high oscillator kept in halt");
cpu_gate_a: assert property (halted |-> !cpu_clk_en) else $error("cpu clocked in halt");
cpu_sys_a: assert property (cpu_clk_en |-> sys_clk_en) else $error("cpu tick without system tick");
tick_pulse_a: assert property (sys_clk_en && ce |=> !sys_clk_en) else $error("short tick gap");
range_hold_a: assert property (crystal_run && $past(crystal_run) |-> $stable(crystal_range))
    else $error("crystal range moved while running");
endmodule // clock_select_control_properties

bind clock_select_control clock_select_control_properties #(.SETTLE_CYCLES(SETTLE_CYCLES),
    .SWITCH_TICKS(SWITCH_TICKS)) props (.*);

// ===== dv/clock_select_control_tb.sv
/*
 * Self-checking bench for the clock select control block: registers, halt, switching.
 * Assumes clock_select_regs.vh on the include path and the checker bound to dut.
 */
`timescale 1ns/1ps
`include "clock_select_regs.vh"
module clock_select_control_tb;
reg clk_sys = 0, rst = 1, ce = 1, avs_read = 0, avs_write = 0, halt_req = 0, wake_req = 0;
reg [2:0] avs_address = 0;
reg [31:0] avs_writedata = 0;
reg [3:0] avs_byteenable = 0;
reg fast_rc_clk = 0, crystal_clk = 0, slow_rc_clk = 0, fast_rc_ready = 0, crystal_ready = 0;
wire [31:0] avs_readdata;
wire [1:0] fast_rc_freq_code;
wire [2:0] power_mode;
wire avs_waitrequest, fast_rc_run, crystal_run, crystal_range, slow_rc_run;
wire cpu_clk_en, sys_clk_en, halted, irq;
reg [63:0] notes[$];
reg [63:0] note;
integer error_cnt = 0, n_compared = 0, cyc = 0, i, k, c, prev, p, el, tcur, r;

clock_select_control #(.SETTLE_CYCLES(8), .SWITCH_TICKS(4)) dut (.clk_sys(clk_sys),
    .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fast_rc_clk(fast_rc_clk), .crystal_clk(crystal_clk), .slow_rc_clk(slow_rc_clk),
    .fast_rc_ready(fast_rc_ready), .crystal_ready(crystal_ready), .fast_rc_run(fast_rc_run),
    .fast_rc_freq_code(fast_rc_freq_code), .crystal_run(crystal_run),
    .crystal_range(crystal_range), .slow_rc_run(slow_rc_run), .halt_req(halt_req),
    .wake_req(wake_req), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .power_mode(power_mode), .halted(halted), .irq(irq));

initial begin
    forever #5 clk_sys = ~clk_sys;
end

// Oscillators stop and lose ready when not run, as real ones would
always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    fast_rc_ready <= fast_rc_run;
    crystal_ready <= crystal_run;
    if (fast_rc_run && cyc % 3 == 0)
        fast_rc_clk <= ~fast_rc_clk;
    if (crystal_run && cyc % 4 == 0)
        crystal_clk <= ~crystal_clk;
    if (slow_rc_run && cyc % 7 == 0)
        slow_rc_clk <= ~slow_rc_clk;
end

// Read results are taken at the edge that samples waitrequest low
always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
        note = notes.pop_front();
        check(avs_readdata & note[63:32], note[31:0]);
    end
end

task check(input [31:0] seen, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
endtask

task bus(input w, input [2:0] a, input [31:0] d, input [3:0] be);
    begin
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        avs_read <= 0;
        avs_write <= 0;
    end
endtask

task wr(input [2:0] a, input [31:0] d);
    bus(1, a, d, 4'h1);
endtask

task rd(input [2:0] a, input [31:0] exp, input [31:0] mask);
    begin
        notes.push_back({mask, exp});
        bus(0, a, 0, 4'h1);
    end
endtask

task meas(output integer per);
    integer n, t0;
    begin
        per = 0;
        t0 = 0;
        for (n = 0; n < 3000 && per == 0; n = n + 1) begin
            @(posedge clk_sys);
            if (sys_clk_en === 1'b1 && t0 != 0)
                per = cyc - t0;
            if (sys_clk_en === 1'b1)
                t0 = cyc;
        end
    end
endtask

task give_verdict;
    begin
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
endtask

// Budget covers the slowest divided switch with wide margin
initial begin
    #400000;
    error_cnt = error_cnt + 1;
    give_verdict;
end

initial begin
    r = $urandom(32'hb855bbea);
    r = $urandom % 4;
    repeat (4) @(posedge clk_sys);
    rst <= 0;
    @(negedge clk_sys);
    check({fast_rc_run, crystal_run, slow_rc_run, halted}, 4'b1010);
    repeat (30) @(posedge clk_sys);
    rd(0, 0, 32'hff);
    rd(1, 3, 32'hff);
    rd(2, 0, 32'hff);
    wr(0, 32'h10);
    rd(0, 0, 32'hff);
    wr(6, $urandom);
    rd(6, 0, 32'hffffffff);
    prev = 0;
    for (i = 0; i < 4; i = i + 1) begin
        c = (i + r) % 4;
        wr(1, c * 4 + 1);
        rd(1, c * 4 + 1 + (c == prev) * 2, 32'hff);
        rd(5, prev << 9, 32'h600);
        @(negedge clk_sys);
        check(fast_rc_freq_code, c);
        repeat (20) @(posedge clk_sys);
        rd(1, c * 4 + 3, 32'hff);
        rd(5, c << 9, 32'h600);
        prev = c;
    end
    wr(1, 0);
    @(negedge clk_sys);
    check(fast_rc_run, 0);
    wr(1, 1);
    rd(1, 1, 32'hff);
    repeat (20) @(posedge clk_sys);
    rd(1, 3, 32'hff);
    wr(2, 32'h04);
    wr(2, 32'h05);
    rd(2, 32'h05, 32'hff);
    wr(2, 32'h05);
    @(negedge clk_sys);
    check({crystal_range, crystal_run}, 2'b11);
    repeat (20) @(posedge clk_sys);
    rd(2, 32'h07, 32'hff);
    check(irq, 0);
    rd(3, 2, 32'h2);
    wr(3, 7);
    bus(1, 4, 32'h2, 4'h0);
    rd(4, 0, 32'hff);
    wr(3, 2);
    wr(4, 2);
    check(irq, 0);
    wr(0, 0);
    for (k = 0; k < 4; k = k + 1) begin
        wr(0, k);
        @(posedge clk_sys);
        halt_req <= 1;
        @(posedge clk_sys);
        halt_req <= 0;
        @(negedge clk_sys);
        c = (12'h95a >> (3 * k)) & 7;
        check({halted, power_mode, cpu_clk_en}, {1'b1, c[2:0], 1'b0});
        check({fast_rc_run, crystal_run, slow_rc_run}, {k[1], k[1], k[0]});
        rd(5, 32'h100 | (c << 5), 32'h1e0);
        @(posedge clk_sys);
        wake_req <= 1;
        @(posedge clk_sys);
        wake_req <= 0;
        @(negedge clk_sys);
        check({halted, power_mode}, 4'h0);
        repeat (20) @(posedge clk_sys);
    end
    halt_req <= 1;
    wake_req <= 1;
    @(posedge clk_sys);
    halt_req <= 0;
    wake_req <= 0;
    @(negedge clk_sys);
    check(halted, 0);
    wr(4, 4);
    tcur = 6;
    for (c = 1; c < 9; c = c + 1) begin
        wr(3, 7);
        wr(0, (c == 8) ? 8'h08 : c * 32);
        el = 0;
        while (irq !== 1'b1 && el < 5000) begin
            @(posedge clk_sys);
            el = el + 1;
        end
        k = (c == 8) ? 8 : (c == 7) ? 14 : 6 << c;
        check(el >= 3 * tcur && el <= 6 * tcur + k + 12, 1);
        meas(p);
        check(p, k);
        rd(5, (c == 8) ? 8 : c, 32'h11f);
        tcur = k;
    end
    give_verdict;
end
endmodule // clock_select_control_tb
